// >>> hdl/vtt_pkg.sv
package vtt_pkg;
  // Geometry
  localparam int NUM_ENTRIES   = 96;   // Roughly one hundred entries
  localparam int IDX_W         = 7;    // Entry index width
  localparam int ADDR_W        = 64;   // Virtual and physical address width
  localparam int SPACE_W       = 8;    // Address space identifier width
  localparam int PERM_W        = 5;    // Permission field width
  localparam int PSIZE_W       = 6;    // Page-size exponent width
  localparam int BASE_SHIFT    = 12;   // 4 KB smallest page
  // Permission bit positions
  localparam int PERM_READ     = 0;
  localparam int PERM_WRITE    = 1;
  localparam int PERM_EXEC     = 2;
  localparam int PERM_SREAD    = 3;
  localparam int PERM_SSTORE   = 4;
  // Access kinds
  localparam logic [2:0] KIND_READ   = 3'h0;
  localparam logic [2:0] KIND_WRITE  = 3'h1;
  localparam logic [2:0] KIND_EXEC   = 3'h2;
  localparam logic [2:0] KIND_SREAD  = 3'h3;
  localparam logic [2:0] KIND_SSTORE = 3'h4;
  // Register offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SPACE   = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_MASK    = 8'h0C;
  localparam logic [7:0] OFF_INDEX   = 8'h10;
  localparam logic [7:0] OFF_VLO     = 8'h14;
  localparam logic [7:0] OFF_VHI     = 8'h18;
  localparam logic [7:0] OFF_PLO     = 8'h1C;
  localparam logic [7:0] OFF_PHI     = 8'h20;
  localparam logic [7:0] OFF_ATTR    = 8'h24;
  localparam logic [7:0] OFF_CMD     = 8'h28;
  localparam logic [7:0] OFF_FAULTLO = 8'h2C;
  localparam logic [7:0] OFF_FAULTHI = 8'h30;
  // Status bit positions
  localparam int ST_MISS   = 0;
  localparam int ST_PERM   = 1;
  localparam int ST_PTRBAD = 2;
  localparam int ST_W      = 3;
  // Attribute layout
  localparam int AT_SPACE  = 0;
  localparam int AT_PRIV   = 8;
  localparam int AT_UNPRIV = 13;
  localparam int AT_VALID  = 18;
  localparam int AT_MOD    = 19;
  localparam int AT_REF    = 20;
  localparam int AT_PSIZE  = 21;
  // Reset values and bus response codes
  localparam logic        CTRL_RST  = 1'h1;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Lookup state machine
  typedef enum logic [2:0] {
    VTT_IDLE = 3'b001,
    VTT_SCAN = 3'b010,
    VTT_DONE = 3'b100
  } vtt_state_e;
endpackage : vtt_pkg

// >>> hdl/vtt_tlb.sv
`timescale 1ns/1ns
// Behaviour
// - Buffer holds ninety-six page mapping entries
// - Missing translation raises trap; kernel refills, retries
// - Virtual base compared above page-size bits
// - Physical base low bits come from virtual
// - Entry carries eight-bit space identifier
// - Five-bit privileged permission field per entry
// - Five-bit unprivileged permission field per entry
// - Only valid entries translate
// - Permitted write or SSTORE hit, when not a pointer check, sets modified flag
// - Permitted hit, when not a pointer check, sets referenced flag
// - Page size is 4 KB shifted by exponent
// - Pointer checked early; bad pointer prefetches handler
// - Software bit enables translation
// - Eight-bit current space register names task
module vtt_tlb
  import vtt_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Access request from the load/store pipeline
  input  wire logic              acc_valid,
  input  wire logic [ADDR_W-1:0] acc_vaddr,
  input  wire logic [2:0]        acc_kind,
  input  wire logic              acc_privileged,
  input  wire logic              acc_is_ptr_check,
  output logic                   acc_ready,
  output logic                   res_valid,
  output logic [ADDR_W-1:0]      res_paddr,
  output logic                   res_trap,
  output logic                   res_perm_fault,
  output logic                   handler_prefetch,
  output logic                   irq,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Entry storage
  logic [ADDR_W-1:0]  entry_virtual_base       [NUM_ENTRIES];
  logic [ADDR_W-1:0]  entry_physical_base      [NUM_ENTRIES];
  logic [SPACE_W-1:0] entry_space_id           [NUM_ENTRIES];
  logic [PERM_W-1:0]  entry_privileged_perms   [NUM_ENTRIES];
  logic [PERM_W-1:0]  entry_unprivileged_perms [NUM_ENTRIES];
  logic               entry_valid_flag         [NUM_ENTRIES];
  logic               entry_modified_flag      [NUM_ENTRIES];
  logic               entry_referenced_flag    [NUM_ENTRIES];
  logic [PSIZE_W-1:0] entry_page_size_exp      [NUM_ENTRIES];
  // Software-visible state
  logic               translation_enable_ctrl_q;  // Translation on
  logic [SPACE_W-1:0] current_space_id_reg_q;     // Running task id
  logic [ST_W-1:0]    status_q;                   // Sticky events
  logic [ST_W-1:0]    mask_q;                     // Interrupt mask
  logic [IDX_W-1:0]   index_q;                    // Selected entry
  logic [63:0]        stage_v_q;                  // Staged virtual base
  logic [63:0]        stage_p_q;                  // Staged physical base
  logic [31:0]        stage_attr_q;               // Staged attributes
  logic [63:0]        fault_addr_q;               // Last trapping address
  // Lookup pipeline
  vtt_state_e         state_q;
  logic [ADDR_W-1:0]  req_vaddr_q;
  logic [2:0]         req_kind_q;
  logic               req_priv_q;
  logic               req_ptr_q;
  logic               hit_q;
  logic [IDX_W-1:0]   hit_idx_q;
  logic [ADDR_W-1:0]  mask_hit_q;
  // Bus handshake state
  logic               aw_held_q;
  logic               w_held_q;
  logic [7:0]         aw_addr_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  // Combinational match results
  logic               match_any;
  logic [IDX_W-1:0]   match_idx;
  logic [ADDR_W-1:0]  match_lowmask;
  logic [PERM_W-1:0]  perms_sel;
  logic               perm_ok;
  logic               wr_fire;
  logic               cmd_write;
  logic               ev_miss;
  logic               ev_perm;
  logic               ev_ptr;
  logic [ST_W-1:0]    ev_vec;
  // Parallel compare against every entry
  always_comb begin
    logic [ADDR_W-1:0] lowm;
    lowm          = '0;
    match_any     = 1'b0;
    match_idx     = '0;
    match_lowmask = '0;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      // Bits below the page boundary bypass the compare
      lowm = (64'h1 << (BASE_SHIFT + int'(entry_page_size_exp[i]))) - 64'h1;
      if (!match_any && entry_valid_flag[i]
          && entry_space_id[i] == current_space_id_reg_q
          && ((entry_virtual_base[i] ^ req_vaddr_q) & ~lowm) == 64'h0) begin
        match_any     = 1'b1;
        match_idx     = IDX_W'(i);
        match_lowmask = lowm;
      end
    end
  end
  // Permissions of the hit entry for the current mode
  always_comb begin
    perms_sel = req_priv_q ? entry_privileged_perms[hit_idx_q]
                           : entry_unprivileged_perms[hit_idx_q];
    unique case (req_kind_q)
      KIND_READ:   perm_ok = perms_sel[PERM_READ];
      KIND_WRITE:  perm_ok = perms_sel[PERM_WRITE];
      KIND_EXEC:   perm_ok = perms_sel[PERM_EXEC];
      KIND_SREAD:  perm_ok = perms_sel[PERM_SREAD];
      KIND_SSTORE: perm_ok = perms_sel[PERM_SSTORE];
      default:     perm_ok = 1'b0;
    endcase
  end
  // Events raised at completion
  assign ev_miss = (state_q == VTT_DONE) && translation_enable_ctrl_q && !hit_q;
  assign ev_perm = (state_q == VTT_DONE) && translation_enable_ctrl_q && hit_q && !perm_ok;
  assign ev_ptr  = (state_q == VTT_DONE) && req_ptr_q && (ev_miss || ev_perm);
  always_comb begin
    ev_vec           = '0;
    ev_vec[ST_MISS]  = ev_miss;
    ev_vec[ST_PERM]  = ev_perm;
    ev_vec[ST_PTRBAD] = ev_ptr;
  end
  // Lookup sequence: capture, compare, answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= VTT_IDLE;
      req_vaddr_q <= '0;
      req_kind_q  <= KIND_READ;
      req_priv_q  <= 1'b0;
      req_ptr_q   <= 1'b0;
      hit_q       <= 1'b0;
      hit_idx_q   <= '0;
      mask_hit_q  <= '0;
    end else begin
      unique case (state_q)
        VTT_IDLE: begin
          // Accept one access at a time
          if (acc_valid) begin
            req_vaddr_q <= acc_vaddr;
            req_kind_q  <= acc_kind;
            req_priv_q  <= acc_privileged;
            req_ptr_q   <= acc_is_ptr_check;
            state_q     <= VTT_SCAN;
          end
        end
        VTT_SCAN: begin
          // Register the compare result
          hit_q      <= match_any;
          hit_idx_q  <= match_idx;
          mask_hit_q <= match_lowmask;
          state_q    <= VTT_DONE;
        end
        VTT_DONE: begin
          state_q <= VTT_IDLE;
        end
      endcase
    end
  end

  // Answer outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ready        <= 1'b0;
      res_valid        <= 1'b0;
      res_paddr        <= '0;
      res_trap         <= 1'b0;
      res_perm_fault   <= 1'b0;
      handler_prefetch <= 1'b0;
    end else begin
      acc_ready        <= (state_q == VTT_IDLE) && acc_valid;
      res_valid        <= (state_q == VTT_DONE);
      res_trap         <= ev_miss || ev_perm;
      res_perm_fault   <= ev_perm;
      handler_prefetch <= ev_ptr;
      if (state_q == VTT_DONE) begin
        if (!translation_enable_ctrl_q)
          res_paddr <= req_vaddr_q;
        else if (hit_q && perm_ok)
          res_paddr <= (entry_physical_base[hit_idx_q] & ~mask_hit_q)
                     | (req_vaddr_q & mask_hit_q);
        else
          res_paddr <= '0;
      end
    end
  end
  // Fault address capture for the trap handler
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fault_addr_q <= '0;
    else if (ev_miss || ev_perm)
      fault_addr_q <= req_vaddr_q;
  end

  // Write channel capture in either order
  assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign cmd_write = wr_fire && aw_addr_q == OFF_CMD && w_strb_q[0] && w_data_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q > OFF_FAULTHI || aw_addr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      translation_enable_ctrl_q <= CTRL_RST;
      current_space_id_reg_q    <= '0;
      mask_q                    <= '0;
      index_q                   <= '0;
      stage_v_q                 <= '0;
      stage_p_q                 <= '0;
      stage_attr_q              <= '0;
    end else if (wr_fire && w_strb_q[0]) begin
      unique case (aw_addr_q)
        OFF_CTRL:  translation_enable_ctrl_q <= w_data_q[0];
        OFF_SPACE: current_space_id_reg_q    <= w_data_q[SPACE_W-1:0];
        OFF_MASK:  mask_q                    <= w_data_q[ST_W-1:0];
        OFF_INDEX: index_q                   <= w_data_q[IDX_W-1:0];
        OFF_VLO:   stage_v_q[31:0]           <= w_data_q;
        OFF_VHI:   stage_v_q[63:32]          <= w_data_q;
        OFF_PLO:   stage_p_q[31:0]           <= w_data_q;
        OFF_PHI:   stage_p_q[63:32]          <= w_data_q;
        OFF_ATTR:  stage_attr_q              <= w_data_q;
        default: ;
      endcase
    end
  end
  // Sticky status; a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      status_q <= '0;
    else if (wr_fire && aw_addr_q == OFF_STATUS && w_strb_q[0])
      status_q <= (status_q & ~w_data_q[ST_W-1:0]) | ev_vec;
    else
      status_q <= status_q | ev_vec;
  end
  // Level interrupt from unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  // Entry array: kernel install and hardware flag updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        entry_valid_flag[i]      <= 1'b0;
        entry_modified_flag[i]   <= 1'b0;
        entry_referenced_flag[i] <= 1'b0;
      end
    end else begin
      if (cmd_write && 32'(index_q) < NUM_ENTRIES) begin
        // Kernel installs the staged entry
        entry_virtual_base[index_q]       <= stage_v_q;
        entry_physical_base[index_q]      <= stage_p_q;
        entry_space_id[index_q]           <= stage_attr_q[AT_SPACE +: SPACE_W];
        entry_privileged_perms[index_q]   <= stage_attr_q[AT_PRIV +: PERM_W];
        entry_unprivileged_perms[index_q] <= stage_attr_q[AT_UNPRIV +: PERM_W];
        entry_valid_flag[index_q]         <= stage_attr_q[AT_VALID];
        entry_modified_flag[index_q]      <= stage_attr_q[AT_MOD];
        entry_referenced_flag[index_q]    <= stage_attr_q[AT_REF];
        entry_page_size_exp[index_q]      <= stage_attr_q[AT_PSIZE +: PSIZE_W];
      end else if (state_q == VTT_DONE && translation_enable_ctrl_q && hit_q && perm_ok
                   && !req_ptr_q) begin
        // Completed access marks the page
        entry_referenced_flag[hit_idx_q] <= 1'b1;
        if (req_kind_q == KIND_WRITE || req_kind_q == KIND_SSTORE)
          entry_modified_flag[hit_idx_q] <= 1'b1;
      end
    end
  end

  // Read channel; one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFF_CTRL:    s_axi_rdata <= {31'h0, translation_enable_ctrl_q};
          OFF_SPACE:   s_axi_rdata <= {24'h0, current_space_id_reg_q};
          OFF_STATUS:  s_axi_rdata <= {29'h0, status_q};
          OFF_MASK:    s_axi_rdata <= {29'h0, mask_q};
          OFF_INDEX:   s_axi_rdata <= {25'h0, index_q};
          OFF_VLO:     s_axi_rdata <= entry_virtual_base[index_q][31:0];
          OFF_VHI:     s_axi_rdata <= entry_virtual_base[index_q][63:32];
          OFF_PLO:     s_axi_rdata <= entry_physical_base[index_q][31:0];
          OFF_PHI:     s_axi_rdata <= entry_physical_base[index_q][63:32];
          OFF_ATTR:    s_axi_rdata <= {5'h0, entry_page_size_exp[index_q], entry_referenced_flag[index_q],
                                       entry_modified_flag[index_q], entry_valid_flag[index_q],
                                       entry_unprivileged_perms[index_q], entry_privileged_perms[index_q],
                                       entry_space_id[index_q]};
          OFF_CMD:     s_axi_rdata <= 32'h0;
          OFF_FAULTLO: s_axi_rdata <= fault_addr_q[31:0];
          OFF_FAULTHI: s_axi_rdata <= fault_addr_q[63:32];
          default: begin
            // Unmapped address
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : vtt_tlb

// >>> test/vtt_tlb_properties.sv
`timescale 1ns/1ns
module vtt_tlb_properties
  import vtt_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              acc_valid,
  input wire logic              acc_ready,
  input wire logic              res_valid,
  input wire logic [ADDR_W-1:0] res_paddr,
  input wire logic              res_trap,
  input wire logic              res_perm_fault,
  input wire logic              handler_prefetch,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  logic [1:0] busy_q;  // Cycles left in a lookup, 0 when idle
  // Mirrors the take, ready and result slots of one lookup
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_q <= 2'h0;
    else if (busy_q != 2'h0) busy_q <= busy_q - 2'h1;
    else if (acc_valid) busy_q <= 2'h3;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  take_ready_a: assert property (acc_valid && busy_q == 2'h0 |=> acc_ready)
    else $error("no acc_ready after take");
  take_result_a: assert property (acc_valid && busy_q == 2'h0 |-> ##3 res_valid)
    else $error("no result three cycles after take");
  result_slot_a: assert property (res_valid |-> busy_q == 2'h1)
    else $error("result outside a lookup slot");
  ready_result_a: assert property ($rose(acc_ready) |-> !res_valid ##2 res_valid)
    else $error("result not two cycles after ready");
  trap_result_a: assert property (res_trap |-> res_valid)
    else $error("trap without result");
  perm_trap_a: assert property (res_valid && res_perm_fault |-> res_trap)
    else $error("permission fault without trap");
  paddr_hold_a: assert property (!res_valid && $past(aresetn) |-> $stable(res_paddr))
    else $error("physical address moved between results");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  prefetch_trap_a: assert property (handler_prefetch |-> res_trap && res_valid)
    else $error("handler prefetch without trapping result");
  cover property (res_valid && res_perm_fault);
  cover property (res_valid && !res_trap);
  cover property (handler_prefetch);
endmodule : vtt_tlb_properties

bind vtt_tlb vtt_tlb_properties u_vtt_tlb_properties (.*);

// >>> test/vtt_lsu_model.sv
`timescale 1ns/1ns
module vtt_lsu_model
  import vtt_pkg::*;
(
  input  wire logic              aclk,
  output logic                   acc_valid,
  output logic [ADDR_W-1:0]      acc_vaddr,
  output logic [2:0]             acc_kind,
  output logic                   acc_privileged,
  output logic                   acc_is_ptr_check,
  input  wire logic              acc_ready,
  input  wire logic              res_valid,
  input  wire logic [ADDR_W-1:0] res_paddr,
  input  wire logic              res_trap,
  input  wire logic              res_perm_fault,
  input  wire logic              handler_prefetch
);
  // Pipeline idle at time zero
  initial begin
    acc_valid        = 1'b0;
    acc_vaddr        = '0;
    acc_kind         = 3'h0;
    acc_privileged   = 1'b0;
    acc_is_ptr_check = 1'b0;
  end
  // One access held until taken; flags come back as {prefetch, perm, trap}
  task automatic access(input logic [63:0] va, input logic [2:0] kd, input logic pv, input logic pc,
                        output logic [63:0] pa, output logic [2:0] fl, output bit ok);
    int n;
    ok = 1'b0;
    fl = 3'h0;
    pa = '0;
    @(posedge aclk);
    acc_valid        <= 1'b1;
    acc_vaddr        <= va;
    acc_kind         <= kd;
    acc_privileged   <= pv;
    acc_is_ptr_check <= pc;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge aclk);
      fl[2] = fl[2] | handler_prefetch;
      if (acc_ready) begin
        acc_valid <= 1'b0;
        acc_vaddr <= ~va;  // Released address shows no stale value
      end
      if (res_valid) begin
        ok      = 1'b1;
        pa      = res_paddr;
        fl[1:0] = {res_perm_fault, res_trap};
      end
    end
    @(posedge aclk);
    fl[2] = fl[2] | handler_prefetch;  // Prefetch rises in the same cycle as the result
  endtask : access
endmodule : vtt_lsu_model

// >>> test/vtt_tlb_bench.sv
`timescale 1ns/1ns
module vtt_tlb_bench
  import vtt_pkg::*;
;
  // 64 KB page (exponent 4) mapped for task SP
  localparam logic [63:0] VB = 64'h8000_0012_3456_0000;
  localparam logic [63:0] PB = 64'h0000_0000_7654_0000;
  localparam logic [63:0] VA = VB | 64'hBEEF;    // Inside the page
  localparam logic [63:0] PA = PB | 64'hBEEF;    // Its translation
  localparam logic [63:0] VX = VA ^ 64'h1_0000;  // Lowest bit above the page flipped
  localparam logic [7:0]  SP = 8'h3C;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;  // Whole-word writes only
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              acc_valid, acc_privileged, acc_is_ptr_check, acc_ready, res_valid;
  logic              res_trap, res_perm_fault, handler_prefetch, irq;
  logic [ADDR_W-1:0] acc_vaddr, res_paddr;
  logic [2:0]        acc_kind;
  int                fail_count = 0, checks_done = 0, k;
  always #25 aclk = ~aclk;  // 20 MHz
  vtt_tlb       u_vtt_tlb (.*);
  vtt_lsu_model u_vtt_lsu_model (.*);
  // Prints the counts and the verdict, then ends the run
  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // A wait ran out: count it and stop
  task automatic give_up();
    fail_count++;
    finish_test();
  endtask : give_up
  task automatic chk_val(input string nm, input logic [63:0] ex, input logic [63:0] sn);
    checks_done++;
    if (sn !== ex) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk_val
  // One register access; ready is raised only once the answer shows
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
    end
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
      s_axi_bready <= s_axi_bvalid;
      s_axi_rready <= s_axi_rvalid;
    end
    if (n == 40) give_up();
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk_val("resp", {62'h0, er}, {62'h0, wr ? s_axi_bresp : s_axi_rresp});
    if (!wr && er === RESP_OKAY) chk_val("rdata", {32'h0, d}, {32'h0, s_axi_rdata});
  endtask : axi
  // Attribute word; fl is {referenced, modified, valid}
  function automatic logic [31:0] attr(input logic [4:0] us, input logic [2:0] fl);
    return {5'h00, 6'h04, fl, us, 5'h1F, SP};
  endfunction : attr
  // Stages both bases and the attributes, then commits at index ix
  task automatic install(input logic [6:0] ix, input logic [31:0] at);
    axi(1'b1, OFF_INDEX, {25'h0, ix}, RESP_OKAY);
    axi(1'b1, OFF_VLO, VB[31:0], RESP_OKAY);
    axi(1'b1, OFF_VHI, VB[63:32], RESP_OKAY);
    axi(1'b1, OFF_PLO, PB[31:0], RESP_OKAY);
    axi(1'b1, OFF_PHI, PB[63:32], RESP_OKAY);
    axi(1'b1, OFF_ATTR, at, RESP_OKAY);
    axi(1'b1, OFF_CMD, 32'h1, RESP_OKAY);
  endtask : install
  // One access; flags always compared, address only without a trap
  task automatic acc(input logic [63:0] va, input logic [2:0] kd, input logic pv, input logic pc,
                     input logic [2:0] ef, input logic [63:0] ep);
    logic [63:0] pa;
    logic [2:0]  fl;
    bit          ok;
    u_vtt_lsu_model.access(va, kd, pv, pc, pa, fl, ok);
    if (!ok) give_up();
    chk_val("flags", {61'h0, ef}, {61'h0, fl});
    if (!ef[0]) chk_val("paddr", ep, pa);
  endtask : acc
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b0, OFF_CTRL, 32'h1, RESP_OKAY);
    axi(1'b0, OFF_SPACE, 32'h0, RESP_OKAY);
    axi(1'b0, 8'hFC, 32'h0, RESP_SLVERR);
    acc(VA, KIND_READ, 1'b0, 1'b0, 3'h1, 64'h0);
    axi(1'b0, OFF_STATUS, 32'h1, RESP_OKAY);
    chk_val("irq", 64'h0, {63'h0, irq});
    axi(1'b1, OFF_MASK, 32'h1, RESP_OKAY);
    @(posedge aclk);
    chk_val("irq", 64'h1, {63'h0, irq});
    axi(1'b1, OFF_STATUS, 32'h1, RESP_OKAY);
    @(posedge aclk);
    chk_val("irq", 64'h0, {63'h0, irq});
    install(7'd95, attr(5'h01, 3'b001));
    axi(1'b1, OFF_SPACE, {24'h0, SP}, RESP_OKAY);
    acc(VA, KIND_READ, 1'b0, 1'b0, 3'h0, PA);
    axi(1'b0, OFF_VHI, VB[63:32], RESP_OKAY);
    axi(1'b0, OFF_PLO, PB[31:0], RESP_OKAY);
    axi(1'b0, OFF_ATTR, attr(5'h01, 3'b101), RESP_OKAY);
    for (k = 0; k < 5; k++) begin
      acc(VA, k[2:0], 1'b1, 1'b0, 3'h0, PA);
      acc(VA, k[2:0], 1'b0, 1'b0, (k == 0) ? 3'h0 : 3'h3, PA);
    end
    axi(1'b0, OFF_ATTR, attr(5'h01, 3'b111), RESP_OKAY);
    acc(VX, KIND_READ, 1'b1, 1'b0, 3'h1, 64'h0);
    acc(VA, KIND_READ, 1'b1, 1'b1, 3'h0, PA);
    acc(VX, KIND_READ, 1'b1, 1'b1, 3'h5, 64'h0);
    axi(1'b0, OFF_FAULTLO, VX[31:0], RESP_OKAY);
    axi(1'b0, OFF_FAULTHI, VX[63:32], RESP_OKAY);
    axi(1'b1, OFF_SPACE, 32'h3D, RESP_OKAY);
    acc(VA, KIND_READ, 1'b1, 1'b0, 3'h1, 64'h0);
    axi(1'b1, OFF_CTRL, 32'h0, RESP_OKAY);
    acc(VX, KIND_WRITE, 1'b0, 1'b0, 3'h0, VX);
    axi(1'b1, OFF_CTRL, 32'h1, RESP_OKAY);
    axi(1'b1, OFF_SPACE, {24'h0, SP}, RESP_OKAY);
    install(7'd95, attr(5'h01, 3'b000));
    acc(VA, KIND_READ, 1'b1, 1'b0, 3'h1, 64'h0);
    axi(1'b1, 8'h40, 32'h0, RESP_SLVERR);
    finish_test();
  end
endmodule : vtt_tlb_bench
